// >>> hw/rxse_pkg.sv
// Constants shared by the receive character status encoder and its self-test checker.
// Behaviour
// - Independent meanings apply when mode reads LL/H.
// - Clean data character gives status 000.
// - Other special code gives status 001.
// - Type-A buffer slip gives 010; Type-B never.
// - Framing character gives 011 with decoded value.
// - Undecodable character gives 100 and C0.7.
// - PLL out of lock gives 101, top priority.
// - Disparity error gives 110 and C4.7/C1.7/C2.7.
// - Self-test data match gives 000.
// - Self-test command match gives 001.
// - Correct final self-test character gives 010.
// - Wrong final self-test character gives 100.
// - Self-test not started, lock loss, slip: 101.
// - Self-test bit mismatch gives 110.
// - Waiting for start character gives 111.
// - Test port supports boundary scan only.
// - Chain holds parallel pins and reference clock.
// - Three-level input scans as 00/10/11.
// - Fixed identification code readable by IDCODE.
package rxse_pkg;
  localparam logic [2:0] ST_NORMAL = 3'h0;
  localparam logic [2:0] ST_SPECIAL = 3'h1;
  localparam logic [2:0] ST_SLIP = 3'h2;
  localparam logic [2:0] ST_FRAMING = 3'h3;
  localparam logic [2:0] ST_VIOLATION = 3'h4;
  localparam logic [2:0] ST_UNLOCK = 3'h5;
  localparam logic [2:0] ST_DISPARITY = 3'h6;
  localparam logic [2:0] ST_WAIT = 3'h7;
  // Replacement characters and the self-test K28.5 character, {K flag, byte}.
  localparam logic [8:0] CHAR_C0_7 = 9'h1E0;
  localparam logic [8:0] CHAR_C1_7 = 9'h1E1;
  localparam logic [8:0] CHAR_C2_7 = 9'h1E2;
  localparam logic [8:0] CHAR_C4_7 = 9'h1E4;
  localparam logic [8:0] CHAR_K28_5 = 9'h1BC;
  // Three-level pin codes.
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_MID = 2'h2;
  localparam logic [1:0] LVL_HIGH = 2'h3;
  // Self-test sequence shape.
  localparam logic [7:0] BIST_LFSR_SEED = 8'h01;
  localparam logic [7:0] BIST_LAST_IDX = 8'h3F;
  localparam logic [7:0] BIST_CMD_MASK = 8'h0F;
  // Test access port.
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_SAMPLE = 4'h1;
  localparam logic [3:0] IR_IDCODE = 4'h2;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam int IR_LEN = 4;
  localparam int BSR_LEN = 26;
  localparam int ID_LEN = 32;
  // Arbitrary neutral identification value; bit 0 must be one.
  localparam logic [31:0] ID_CODE = 32'h0000_0001;
  // Pin synchroniser layout.
  localparam int PIN_W = 11;
endpackage : rxse_pkg

// >>> hw/rxse_bist_checker.sv
// Receive self-test sequence tracker and character comparator.
`timescale 1ns/1ps
module rxse_bist_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic bistEn,
  // Decoded character
  input wire logic charStrobe,
  input wire logic [7:0] charData,
  input wire logic charIsK,
  // Result for the current character
  output logic [2:0] bistCode
);
  typedef enum logic [1:0] {BIST_IDLE, BIST_START, BIST_WAIT, BIST_CMP} rxse_bist_type;
  rxse_bist_type state_q, state_d;
  logic [7:0] lfsr_q, lfsr_d;
  logic [7:0] idx_q, idx_d;
  logic [8:0] expected;
  logic match;

  function automatic logic [7:0] lfsrNext(input logic [7:0] v);
    lfsrNext = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsrNext

  always_comb
  begin
    state_d = state_q;
    lfsr_d = lfsr_q;
    idx_d = idx_q;
    bistCode = rxse_pkg::ST_UNLOCK;
    // Commands sit at fixed positions so that no extra state is kept per character.
    expected = ((idx_q & rxse_pkg::BIST_CMD_MASK) == 8'h00 || idx_q == rxse_pkg::BIST_LAST_IDX)
      ? rxse_pkg::CHAR_K28_5 : {1'b0, lfsr_q};
    match = ({charIsK, charData} == expected);
    case (state_q)
      BIST_IDLE:
      begin
        if (bistEn)
          state_d = BIST_START;
      end
      BIST_START:
      begin
        bistCode = rxse_pkg::ST_UNLOCK;
        if (charStrobe)
          state_d = BIST_WAIT;
      end
      BIST_WAIT:
      begin
        bistCode = rxse_pkg::ST_WAIT;
        if (charStrobe && {charIsK, charData} == rxse_pkg::CHAR_K28_5)
        begin
          state_d = BIST_CMP;
          lfsr_d = rxse_pkg::BIST_LFSR_SEED;
          idx_d = 8'h01;
        end
      end
      BIST_CMP:
      begin
        if (idx_q == rxse_pkg::BIST_LAST_IDX)
          bistCode = match ? rxse_pkg::ST_SLIP : rxse_pkg::ST_VIOLATION;
        else if (!match)
          bistCode = rxse_pkg::ST_DISPARITY;
        else
          bistCode = expected[8] ? rxse_pkg::ST_SPECIAL : rxse_pkg::ST_NORMAL;
        if (charStrobe)
        begin
          idx_d = idx_q + 8'h01;
          if (!expected[8])
            lfsr_d = lfsrNext(lfsr_q);
          if (idx_q == rxse_pkg::BIST_LAST_IDX)
            state_d = BIST_WAIT;
        end
      end
      default:
        state_d = BIST_IDLE;
    endcase
    if (!bistEn)
      state_d = BIST_IDLE;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_q <= BIST_IDLE;
      lfsr_q <= 8'h00;
      idx_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      lfsr_q <= lfsr_d;
      idx_q <= idx_d;
    end
  end

  property p_bist_start;
    @(posedge clk_sys) disable iff (rst)
    (state_q == BIST_START && bistEn && charStrobe) |->
      bistCode == rxse_pkg::ST_UNLOCK ##1 state_q == BIST_WAIT;
  endproperty
  a_bist_start: assert property (p_bist_start) else $error("Self-test start code wrong.");

  property p_bist_wait;
    @(posedge clk_sys) disable iff (rst)
    (state_q == BIST_WAIT && bistEn && charStrobe && charIsK && charData == 8'hBC) |->
      bistCode == rxse_pkg::ST_WAIT ##1 (state_q == BIST_CMP && idx_q == 8'h01);
  endproperty
  a_bist_wait: assert property (p_bist_wait) else $error("Self-test wait exit wrong.");
endmodule : rxse_bist_checker

// >>> hw/rxse_top.sv
// Receive character status encoder with boundary-scan test access port.
`timescale 1ns/1ps
module rxse_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Static pins, asynchronous to clk_sys
  input wire logic referenceClockInput,
  input wire logic [3:0] rxModeSelector,
  input wire logic statusTypeB,
  input wire logic bistEnable,
  input wire logic pllLocked,
  // Decoder, framer and elasticity buffer
  input wire logic charStrobe,
  input wire logic [7:0] charData,
  input wire logic charIsK,
  input wire logic codeViolation,
  input wire logic disparityError,
  input wire logic framingMatch,
  input wire logic ebufError,
  input wire logic [2:0] bondedStatus,
  // Parallel receive bus
  output logic rxCharValid,
  output logic [7:0] rxCharData,
  output logic rxCharIsK,
  output logic [2:0] rx_char_status_code,
  // Test access port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdoEn
);
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR,
    TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
    TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } rxse_tap_type;

  logic [rxse_pkg::PIN_W-1:0] pinMeta_q, pinSync_q;
  logic refClkS, typeBS, bistS, lockS, tckS, tmsS, tdiS;
  logic [3:0] modeS;
  logic independent, pllLoss;
  logic [2:0] bistCode;
  logic [2:0] code;
  logic [8:0] outChar;
  logic valid_q, valid_d, isK_q, isK_d;
  logic [7:0] data_q, data_d;
  logic [2:0] status_q, status_d;
  rxse_tap_type tap_q, tap_d;
  logic tckPrev_q;
  logic tckRise, tckFall;
  logic [rxse_pkg::IR_LEN-1:0] irSh_q, irSh_d, ir_q, ir_d;
  logic [rxse_pkg::ID_LEN-1:0] dr_q, dr_d;
  logic [11:0] upd_q, upd_d;
  logic tdo_q, tdo_d, tdoEn_q, tdoEn_d;
  logic [rxse_pkg::BSR_LEN-1:0] bsr;

  // Every pin is used only as a slow level, so a two-stage sampler is enough.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
    end
    else
    begin
      pinMeta_q <= {referenceClockInput, rxModeSelector, statusTypeB, bistEnable, pllLocked,
        tck, tms, tdi};
      pinSync_q <= pinMeta_q;
    end
  end
  assign {refClkS, modeS, typeBS, bistS, lockS, tckS, tmsS, tdiS} = pinSync_q;

  // Mode pin 1 low and mode pin 0 low or high selects independent channels.
  assign independent = (modeS[3:2] == rxse_pkg::LVL_LOW) &&
    (modeS[1:0] == rxse_pkg::LVL_LOW || modeS[1:0] == rxse_pkg::LVL_HIGH);
  assign pllLoss = !lockS;

  rxse_bist_checker u_bist (
    .clk_sys(clk_sys),
    .rst(rst),
    .bistEn(bistS),
    .charStrobe(charStrobe),
    .charData(charData),
    .charIsK(charIsK),
    .bistCode(bistCode)
  );

  // Conditions are tested in priority order: lock loss, buffer slip, violation, framing, disparity, special.
  always_comb
  begin
    outChar = {charIsK, charData};
    code = rxse_pkg::ST_NORMAL;
    if (bistS)
    begin
      if (pllLoss || ebufError)
        code = rxse_pkg::ST_UNLOCK;
      else
        code = bistCode;
    end
    else if (independent)
    begin
      if (pllLoss)
        code = rxse_pkg::ST_UNLOCK;
      else if (ebufError)
        code = typeBS ? rxse_pkg::ST_UNLOCK : rxse_pkg::ST_SLIP;
      else if (codeViolation)
      begin
        code = rxse_pkg::ST_VIOLATION;
        outChar = rxse_pkg::CHAR_C0_7;
      end
      else if (framingMatch)
        code = rxse_pkg::ST_FRAMING;
      else if (disparityError)
      begin
        code = rxse_pkg::ST_DISPARITY;
        if (outChar != rxse_pkg::CHAR_C1_7 && outChar != rxse_pkg::CHAR_C2_7)
          outChar = rxse_pkg::CHAR_C4_7;
      end
      else if (charIsK)
        code = rxse_pkg::ST_SPECIAL;
      else
        code = rxse_pkg::ST_NORMAL;
    end
    else
      code = bondedStatus;
  end

  // In EXTEST the bus pins show the boundary update cells instead of live traffic.
  always_comb
  begin
    valid_d = charStrobe;
    data_d = data_q;
    isK_d = isK_q;
    status_d = status_q;
    if (ir_q == rxse_pkg::IR_EXTEST)
    begin
      valid_d = 1'b0;
      {status_d, isK_d, data_d} = upd_q;
    end
    else if (charStrobe)
    begin
      {isK_d, data_d} = outChar;
      status_d = code;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      valid_q <= 1'b0;
      data_q <= 8'h00;
      isK_q <= 1'b0;
      status_q <= rxse_pkg::ST_NORMAL;
    end
    else
    begin
      valid_q <= valid_d;
      data_q <= data_d;
      isK_q <= isK_d;
      status_q <= status_d;
    end
  end
  assign rxCharValid = valid_q;
  assign rxCharData = data_q;
  assign rxCharIsK = isK_q;
  assign rx_char_status_code = status_q;

  // Serial pins are absent; three-level mode pins take two cells each.
  assign bsr = {status_q, isK_q, data_q, modeS, refClkS, charIsK, charData};

  function automatic int drLen(input logic [3:0] ir);
    case (ir)
      rxse_pkg::IR_IDCODE: drLen = rxse_pkg::ID_LEN;
      rxse_pkg::IR_EXTEST, rxse_pkg::IR_SAMPLE: drLen = rxse_pkg::BSR_LEN;
      default: drLen = 1;
    endcase
  endfunction : drLen

  assign tckRise = tckS && !tckPrev_q;
  assign tckFall = !tckS && tckPrev_q;

  // The port runs off sampled pins, so tck must stay well below a quarter of clk_sys.
  always_comb
  begin
    tap_d = tap_q;
    irSh_d = irSh_q;
    ir_d = ir_q;
    dr_d = dr_q;
    upd_d = upd_q;
    tdo_d = tdo_q;
    tdoEn_d = tdoEn_q;
    if (tckRise)
    begin
      case (tap_q)
        TAP_CAP_DR:
        begin
          if (ir_q == rxse_pkg::IR_IDCODE)
            dr_d = rxse_pkg::ID_CODE;
          else if (ir_q == rxse_pkg::IR_EXTEST || ir_q == rxse_pkg::IR_SAMPLE)
            dr_d = {{(rxse_pkg::ID_LEN - rxse_pkg::BSR_LEN){1'b0}}, bsr};
          else
            dr_d = '0;
        end
        TAP_SHIFT_DR:
        begin
          dr_d = dr_q >> 1;
          dr_d[drLen(ir_q) - 1] = tdiS;
        end
        TAP_UPD_DR:
        begin
          if (ir_q == rxse_pkg::IR_EXTEST)
            upd_d = dr_q[rxse_pkg::BSR_LEN-1:rxse_pkg::BSR_LEN-12];
        end
        TAP_CAP_IR: irSh_d = rxse_pkg::IR_CAPTURE;
        TAP_SHIFT_IR: irSh_d = {tdiS, irSh_q[rxse_pkg::IR_LEN-1:1]};
        TAP_UPD_IR:
        begin
          // Unsupported codes fall back to bypass; only boundary scan is offered.
          if (irSh_q == rxse_pkg::IR_EXTEST || irSh_q == rxse_pkg::IR_SAMPLE ||
              irSh_q == rxse_pkg::IR_IDCODE)
            ir_d = irSh_q;
          else
            ir_d = rxse_pkg::IR_BYPASS;
        end
        default:
        begin
        end
      endcase
      case (tap_q)
        TAP_RESET: tap_d = tmsS ? TAP_RESET : TAP_IDLE;
        TAP_IDLE: tap_d = tmsS ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_DR: tap_d = tmsS ? TAP_SEL_IR : TAP_CAP_DR;
        TAP_CAP_DR: tap_d = tmsS ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_SHIFT_DR: tap_d = tmsS ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_EXIT1_DR: tap_d = tmsS ? TAP_UPD_DR : TAP_PAUSE_DR;
        TAP_PAUSE_DR: tap_d = tmsS ? TAP_EXIT2_DR : TAP_PAUSE_DR;
        TAP_EXIT2_DR: tap_d = tmsS ? TAP_UPD_DR : TAP_SHIFT_DR;
        TAP_UPD_DR: tap_d = tmsS ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_IR: tap_d = tmsS ? TAP_RESET : TAP_CAP_IR;
        TAP_CAP_IR: tap_d = tmsS ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_SHIFT_IR: tap_d = tmsS ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_EXIT1_IR: tap_d = tmsS ? TAP_UPD_IR : TAP_PAUSE_IR;
        TAP_PAUSE_IR: tap_d = tmsS ? TAP_EXIT2_IR : TAP_PAUSE_IR;
        TAP_EXIT2_IR: tap_d = tmsS ? TAP_UPD_IR : TAP_SHIFT_IR;
        TAP_UPD_IR: tap_d = tmsS ? TAP_SEL_DR : TAP_IDLE;
        default: tap_d = TAP_RESET;
      endcase
    end
    if (tap_q == TAP_RESET)
      ir_d = rxse_pkg::IR_IDCODE;
    if (tckFall)
    begin
      tdoEn_d = (tap_q == TAP_SHIFT_DR) || (tap_q == TAP_SHIFT_IR);
      tdo_d = (tap_q == TAP_SHIFT_IR) ? irSh_q[0] : dr_q[0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tap_q <= TAP_RESET;
      tckPrev_q <= 1'b0;
      irSh_q <= '0;
      ir_q <= rxse_pkg::IR_IDCODE;
      dr_q <= '0;
      upd_q <= '0;
      tdo_q <= 1'b0;
      tdoEn_q <= 1'b0;
    end
    else
    begin
      tap_q <= tap_d;
      tckPrev_q <= tckS;
      irSh_q <= irSh_d;
      ir_q <= ir_d;
      dr_q <= dr_d;
      upd_q <= upd_d;
      tdo_q <= tdo_d;
      tdoEn_q <= tdoEn_d;
    end
  end
  assign tdo = tdo_q;
  assign tdoEn = tdoEn_q;

  property p_pll_wins;
    @(posedge clk_sys) disable iff (rst)
    (charStrobe && independent && !bistS && pllLoss && ir_q != rxse_pkg::IR_EXTEST) |=>
      (rxCharValid && rx_char_status_code == 3'h5);
  endproperty
  a_pll_wins: assert property (p_pll_wins) else $error("Lock loss not reported.");

  property p_violation;
    @(posedge clk_sys) disable iff (rst)
    (charStrobe && independent && !bistS && lockS && !ebufError && codeViolation &&
      ir_q != rxse_pkg::IR_EXTEST) |=>
      (rx_char_status_code == 3'h4 && rxCharIsK && rxCharData == 8'hE0);
  endproperty
  a_violation: assert property (p_violation) else $error("Violation not C0.7.");

  property p_typeb_slip;
    @(posedge clk_sys) disable iff (rst)
    (charStrobe && independent && !bistS && typeBS && ir_q != rxse_pkg::IR_EXTEST) |=>
      rx_char_status_code != 3'h2;
  endproperty
  a_typeb_slip: assert property (p_typeb_slip) else $error("Type-B slip code used.");

  property p_disparity;
    @(posedge clk_sys) disable iff (rst)
    (charStrobe && independent && !bistS && lockS && !ebufError && !codeViolation &&
      !framingMatch && disparityError && ir_q != rxse_pkg::IR_EXTEST) |=>
      (rx_char_status_code == 3'h6 && rxCharIsK && rxCharData[7:5] == 3'h7);
  endproperty
  a_disparity: assert property (p_disparity) else $error("Disparity status wrong.");

  property p_normal;
    @(posedge clk_sys) disable iff (rst)
    (charStrobe && independent && !bistS && lockS && !ebufError && !codeViolation &&
      !framingMatch && !disparityError && !charIsK && ir_q != rxse_pkg::IR_EXTEST) |=>
      (rx_char_status_code == 3'h0 && rxCharData == $past(charData));
  endproperty
  a_normal: assert property (p_normal) else $error("Normal character mangled.");

  property p_bist_lock;
    @(posedge clk_sys) disable iff (rst)
    (charStrobe && bistS && (pllLoss || ebufError) && ir_q != rxse_pkg::IR_EXTEST) |=>
      rx_char_status_code == 3'h5;
  endproperty
  a_bist_lock: assert property (p_bist_lock) else $error("Self-test lock loss missed.");

  property p_idcode;
    @(posedge clk_sys) disable iff (rst)
    (tckRise && tap_q == TAP_CAP_DR && ir_q == rxse_pkg::IR_IDCODE) |=>
      (dr_q == rxse_pkg::ID_CODE && tap_q != TAP_CAP_DR);
  endproperty
  a_idcode: assert property (p_idcode) else $error("Identification code not captured.");
endmodule : rxse_top

// >>> tb/rxse_host_model.sv
// Host-side receiver model that latches each character from the parallel receive bus.
`timescale 1ns/1ps
module rxse_host_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Parallel receive bus
  input wire logic rxCharValid,
  input wire logic [7:0] rxCharData,
  input wire logic rxCharIsK,
  input wire logic [2:0] rx_char_status_code,
  // Captured character
  output logic gotValid,
  output logic [7:0] gotData,
  output logic gotIsK,
  output logic [2:0] gotStatus
);
  // The bus is only taken on the valid cycle, so data held between characters is never trusted.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      gotValid <= 1'b0;
      gotData <= 8'h00;
      gotIsK <= 1'b0;
      gotStatus <= 3'h0;
    end
    else
    begin
      gotValid <= rxCharValid;
      if (rxCharValid)
      begin
        gotData <= rxCharData;
        gotIsK <= rxCharIsK;
        gotStatus <= rx_char_status_code;
      end
    end
  end
endmodule : rxse_host_model

// >>> tb/test_rx_char_status_encoder.sv
// Self-checking bench for the receive character status encoder.
`timescale 1ns/1ps
module test_rx_char_status_encoder;
  typedef struct {logic [2:0] st; logic [7:0] d; logic k; bit cs; bit cd;} rxse_exp_type;
  logic clk_sys, rst, referenceClockInput, statusTypeB, bistEnable, pllLocked;
  logic charStrobe, charIsK, codeViolation, disparityError, framingMatch, ebufError;
  logic tck, tms, tdi, rxCharValid, rxCharIsK, tdo, tdoEn, gotValid, gotIsK, bitOut, enSeen;
  logic [3:0] rxModeSelector;
  logic [7:0] charData, rxCharData, gotData, rd;
  logic [2:0] bondedStatus, rx_char_status_code, gotStatus;
  logic [31:0] shiftOut;
  rxse_exp_type expQ[$];
  rxse_exp_type curExp;
  int unsigned seedRet;
  int error_cnt = 0;
  int num_checks = 0;

  rxse_top u_dut (.clk_sys(clk_sys), .rst(rst), .referenceClockInput(referenceClockInput),
    .rxModeSelector(rxModeSelector), .statusTypeB(statusTypeB), .bistEnable(bistEnable),
    .pllLocked(pllLocked), .charStrobe(charStrobe), .charData(charData), .charIsK(charIsK),
    .codeViolation(codeViolation), .disparityError(disparityError),
    .framingMatch(framingMatch), .ebufError(ebufError), .bondedStatus(bondedStatus),
    .rxCharValid(rxCharValid), .rxCharData(rxCharData), .rxCharIsK(rxCharIsK),
    .rx_char_status_code(rx_char_status_code), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdoEn(tdoEn));

  rxse_host_model u_host (.clk_sys(clk_sys), .rst(rst), .rxCharValid(rxCharValid),
    .rxCharData(rxCharData), .rxCharIsK(rxCharIsK),
    .rx_char_status_code(rx_char_status_code), .gotValid(gotValid), .gotData(gotData),
    .gotIsK(gotIsK), .gotStatus(gotStatus));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [31:0] expV, input logic [31:0] gotV);
    num_checks++;
    if (gotV !== expV)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, expV, gotV);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  // Qualifier nibble q is {violation, disparity, framing, buffer error}.
  task automatic send(input logic [7:0] d, input logic k, input logic [3:0] q,
    input logic [2:0] st, input logic [7:0] ed, input logic ek, input bit cd, input bit cs = 1);
    @(posedge clk_sys);
    #1;
    charStrobe = 1'b1;
    charData = d;
    charIsK = k;
    {codeViolation, disparityError, framingMatch, ebufError} = q;
    expQ.push_back('{st, ed, ek, cs, cd});
  endtask : send

  task automatic idle(input int n);
    @(posedge clk_sys);
    #1;
    charStrobe = 1'b0;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle

  task automatic endTest(input string name);
    idle(6);
    check("pending results", 32'h0, expQ.size());
    $display("test %s done", name);
  endtask : endTest

  // Results are matched in order, so a dropped or extra character shows up at once.
  always @(posedge clk_sys)
  begin
    if (gotValid === 1'b1)
    begin
      if (expQ.size() == 0)
        check("unexpected character", 32'h0, 32'h1);
      else
      begin
        curExp = expQ.pop_front();
        if (curExp.cs)
          check("status", curExp.st, gotStatus);
        if (curExp.cd)
          check("character", {curExp.k, curExp.d}, {gotIsK, gotData});
      end
    end
  end

  // Half periods of eight clocks leave room for the pin synchroniser and the tdo update.
  task automatic tapStep(input logic m, input logic di, output logic dout);
    tms = m;
    tdi = di;
    repeat (8) @(posedge clk_sys);
    dout = tdo;
    #1;
    tck = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    tck = 1'b0;
  endtask : tapStep

  task automatic gotoShift(input bit ir);
    tapStep(1'b1, 1'b0, bitOut);
    if (ir)
      tapStep(1'b1, 1'b0, bitOut);
    tapStep(1'b0, 1'b0, bitOut);
    tapStep(1'b0, 1'b0, bitOut);
  endtask : gotoShift

  task automatic shiftBits(input int n, input logic [31:0] din);
    for (int i = 0; i < n; i++)
    begin
      tapStep(i == n - 1, din[i], bitOut);
      shiftOut[i] = bitOut;
      if (i == 0)
        enSeen = tdoEn;
    end
    tapStep(1'b1, 1'b0, bitOut);
    tapStep(1'b0, 1'b0, bitOut);
  endtask : shiftBits

  task automatic bistRun(input bit good);
    logic [7:0] lf;
    lf = rxse_pkg::BIST_LFSR_SEED;
    send(8'hBC, 1'b1, 4'h0, 3'h7, 8'h00, 1'b0, 1'b0);
    for (int i = 1; i < 64; i++)
    begin
      if (i == 63 && good)
        send(8'hBC, 1'b1, 4'h0, 3'h2, 8'h00, 1'b0, 1'b0);
      else if (i == 63)
        send(8'h00, 1'b0, 4'h0, 3'h4, 8'h00, 1'b0, 1'b0);
      else if (i % 16 == 0)
        send(8'hBC, 1'b1, 4'h0, 3'h1, 8'h00, 1'b0, 1'b0);
      else if (good)
        send(lf, 1'b0, 4'h0, 3'h0, lf, 1'b0, 1'b1);
      else
        send(lf ^ 8'h80, 1'b0, 4'h0, 3'h6, 8'h00, 1'b0, 1'b0);
      // The pattern advances on data positions and the final position, never on the other command positions.
      if (i % 16 != 0)
        lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    end
  endtask : bistRun

  initial
  begin
    #300000;
    error_cnt++;
    complete_run();
  end

  initial
  begin
    rst = 1'b1;
    {referenceClockInput, statusTypeB, bistEnable, charStrobe, charIsK, tck, tdi} = '0;
    {codeViolation, disparityError, framingMatch, ebufError} = 4'h0;
    rxModeSelector = 4'h0;
    pllLocked = 1'b1;
    charData = 8'h00;
    bondedStatus = 3'h0;
    tms = 1'b1;
    seedRet = $urandom(32'h31aa_ba94);
    repeat (10) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    idle(5);
    rd = 8'($urandom());
    send(rd, 1'b0, 4'h0, 3'h0, rd, 1'b0, 1'b1);
    send(8'h7C, 1'b1, 4'h0, 3'h1, 8'h7C, 1'b1, 1'b1);
    send(8'hBC, 1'b1, 4'h2, 3'h3, 8'hBC, 1'b1, 1'b1);
    send(8'h55, 1'b0, 4'h8, 3'h4, 8'hE0, 1'b1, 1'b1);
    send(8'h55, 1'b0, 4'h4, 3'h6, 8'hE4, 1'b1, 1'b1);
    send(8'hE1, 1'b1, 4'h4, 3'h6, 8'hE1, 1'b1, 1'b1);
    send(8'hE2, 1'b1, 4'h4, 3'h6, 8'hE2, 1'b1, 1'b1);
    send(8'h55, 1'b0, 4'hC, 3'h4, 8'hE0, 1'b1, 1'b1);
    send(8'hBC, 1'b1, 4'h6, 3'h3, 8'hBC, 1'b1, 1'b1);
    send(8'h55, 1'b0, 4'h1, 3'h2, 8'h00, 1'b0, 1'b0);
    send(8'h55, 1'b0, 4'hB, 3'h2, 8'h00, 1'b0, 1'b0);
    rxModeSelector = 4'h3;
    idle(4);
    rd = 8'($urandom());
    send(rd, 1'b0, 4'h0, 3'h0, rd, 1'b0, 1'b1);
    statusTypeB = 1'b1;
    idle(4);
    send(8'h55, 1'b0, 4'h1, 3'h5, 8'h00, 1'b0, 1'b0);
    pllLocked = 1'b0;
    idle(4);
    send(8'h55, 1'b0, 4'h9, 3'h5, 8'h00, 1'b0, 1'b0);
    pllLocked = 1'b1;
    for (int m = 0; m < 2; m++)
    begin
      rxModeSelector = m ? 4'hC : 4'h8;
      // The previous character still waits for its edge, so the bonded code changes after it.
      idle(4);
      bondedStatus = 3'($urandom());
      send(8'h55, 1'b0, 4'h0, bondedStatus, 8'h00, 1'b0, 1'b0);
    end
    endTest("independent");
    bistEnable = 1'b1;
    idle(4);
    send(8'h00, 1'b0, 4'h0, 3'h5, 8'h00, 1'b0, 1'b0);
    send(8'h00, 1'b0, 4'h0, 3'h7, 8'h00, 1'b0, 1'b0);
    bistRun(1'b1);
    send(8'h00, 1'b0, 4'h0, 3'h7, 8'h00, 1'b0, 1'b0);
    bistRun(1'b0);
    send(8'h00, 1'b0, 4'h1, 3'h5, 8'h00, 1'b0, 1'b0);
    pllLocked = 1'b0;
    idle(4);
    send(8'h00, 1'b0, 4'h0, 3'h5, 8'h00, 1'b0, 1'b0);
    endTest("self test");
    {bistEnable, charIsK, pllLocked, referenceClockInput} = 4'b0011;
    charData = 8'hA5;
    rxModeSelector = 4'h8;
    for (int i = 0; i < 5; i++)
      tapStep(1'b1, 1'b0, bitOut);
    tapStep(1'b0, 1'b0, bitOut);
    gotoShift(1'b0);
    shiftBits(32, 32'h0);
    check("identification", rxse_pkg::ID_CODE, shiftOut);
    check("tdo enable", 32'h1, enSeen);
    gotoShift(1'b1);
    shiftBits(4, 32'(rxse_pkg::IR_SAMPLE));
    check("instruction capture", rxse_pkg::IR_CAPTURE, shiftOut[3:0]);
    gotoShift(1'b0);
    shiftBits(26, 32'h0);
    check("boundary inputs", {18'h0, 4'h8, 2'b10, 8'hA5}, shiftOut[13:0]);
    check("boundary outputs", {20'h0, 12'hA00}, shiftOut[25:14]);
    gotoShift(1'b1);
    shiftBits(4, 32'(rxse_pkg::IR_EXTEST));
    gotoShift(1'b0);
    shiftBits(26, 32'h034F_0000);
    check("update cells", {20'h0, 12'hD3C}, {rx_char_status_code, rxCharIsK, rxCharData});
    check("valid in update", 32'h0, rxCharValid);
    $display("test scan done");
    complete_run();
  end
endmodule : test_rx_char_status_encoder
